// ### dv/ccs_mem_model.sv
// shared memory model answering the scheduler's word requests
`timescale 1ns/1ps
`default_nettype none
module ccs_mem_model #(
  parameter int ADDR_W = 24
) (
  input  wire logic              clk_i,
  input  wire logic              req_i,
  input  wire logic              we_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [15:0]       wdata_i,
  output logic                   ack_o = 1'b0,
  output logic [15:0]            rdata_o = 16'h0000
);
  logic [15:0] mem [int];
  int          lag = 0;
  // random lag per answer; data scrambles outside the answer cycle
  always @(posedge clk_i)
  begin
    ack_o <= 1'b0;
    rdata_o <= ~rdata_o;
    if (req_i && !ack_o && lag > 0)
      lag--;
    else if (req_i && !ack_o)
    begin
      ack_o <= 1'b1;
      rdata_o <= peek(addr_i);
      if (we_i)
        mem[int'(addr_i)] = wdata_i;
      lag = $urandom_range(3, 0);
    end
  end
  function automatic logic [15:0] peek(input logic [ADDR_W-1:0] a);
    return mem.exists(int'(a)) ? mem[int'(a)] : 16'h0000;
  endfunction : peek
  task automatic poke(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    mem[int'(a)] = d;
  endtask : poke
endmodule : ccs_mem_model
`default_nettype wire

// ### dv/ccs_sched_sva.sv
// assertion checker for the channel context scheduler
`timescale 1ns/1ps
`default_nettype none
module ccs_sched_sva import ccs_pkg::*; #(
  parameter int ADDR_W = 24
) (
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              lmi_auto_i,
  input wire logic [ADDR_W-1:0] context_table_base_i,
  input wire logic              tx_done_i,
  input wire logic              tx_taken_i,
  input wire logic              mem_ack_i,
  input wire logic              mem_req_o,
  input wire logic              mem_we_o,
  input wire logic [ADDR_W-1:0] mem_addr_o,
  input wire logic              tx_start_o,
  input wire ccs_tx_req_t       tx_req_o,
  input wire logic              rx_go_o,
  input wire logic              rx_drop_o,
  input wire logic              send_enquiry_o,
  input wire logic              user_poll_err_o,
  input wire logic              network_poll_err_o,
  input wire logic              user_poll_prim_o,
  input wire logic              network_poll_prim_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence mem_wait_s;
    mem_req_o && !mem_ack_i;
  endsequence
  sequence wb_s;
    mem_req_o && mem_we_o;
  endsequence
  mem_hold_a: assert property (mem_wait_s |=> mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o))
    else $error("memory request changed before ack");
  mem_gap_a: assert property (mem_req_o && mem_ack_i |=> !mem_req_o)
    else $error("memory request not released after ack");
  wb_addr_a: assert property (wb_s |-> mem_addr_o == context_table_base_i + (ADDR_W'(tx_req_o.entry) << 5) + ADDR_W'(2))
    else $error("index write-back at wrong address");
  wb_taken_a: assert property (tx_done_i && tx_taken_i |-> ##[1:16] wb_s)
    else $error("taken frame without index write-back");
  wb_skip_a: assert property (tx_done_i && !tx_taken_i |=> !(mem_req_o && mem_we_o) [*8])
    else $error("index advanced without a taken frame");
  tx_pulse_a: assert property (tx_start_o |=> !tx_start_o && $stable(tx_req_o))
    else $error("transmit start not a single pulse");
  rx_once_a: assert property (rx_go_o || rx_drop_o |-> !(rx_go_o && rx_drop_o) ##1 !(rx_go_o || rx_drop_o))
    else $error("receive accept and discard overlap");
  uprim_mode_a: assert property (user_poll_prim_o |-> !lmi_auto_i)
    else $error("user poll primitive in automatic mode");
  nprim_mode_a: assert property (network_poll_prim_o |-> !lmi_auto_i)
    else $error("network poll primitive in automatic mode");
  auto_ev_a: assert property (send_enquiry_o || network_poll_err_o |-> lmi_auto_i)
    else $error("automatic timer action in manual mode");
  uerr_enq_a: assert property (user_poll_err_o |-> send_enquiry_o)
    else $error("user poll error without a new enquiry");
endmodule : ccs_sched_sva
bind ccs_sched ccs_sched_sva #(.ADDR_W(ADDR_W)) i_ccs_sched_sva (
  .clk_i(clk_i), .rst_i(rst_i), .lmi_auto_i(lmi_auto_i), .context_table_base_i(context_table_base_i),
  .tx_done_i(tx_done_i), .tx_taken_i(tx_taken_i), .mem_ack_i(mem_ack_i), .mem_req_o(mem_req_o),
  .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o), .tx_start_o(tx_start_o), .tx_req_o(tx_req_o),
  .rx_go_o(rx_go_o), .rx_drop_o(rx_drop_o), .send_enquiry_o(send_enquiry_o),
  .user_poll_err_o(user_poll_err_o), .network_poll_err_o(network_poll_err_o),
  .user_poll_prim_o(user_poll_prim_o), .network_poll_prim_o(network_poll_prim_o)
);
`default_nettype wire

// ### dv/ccs_sched_tb.sv
// self-checking bench for the channel context scheduler
`timescale 1ns/1ps
`default_nettype none
module ccs_sched_tb import ccs_pkg::*;;
  localparam logic [39:0] INIT_TAB [16] = '{
    40'h001020a000, 40'h0010244000, 40'h0010261234, 40'h0010285678, 40'h0010300028, 40'h0010328100,
    40'h0010366000, 40'h0010a08100, 40'h0010a44100, 40'h0010a69abc, 40'h0010a8def0, 40'h0040008000,
    40'h0041008000, 40'h0080068001, 40'h0080080001, 40'h00800a8005};
  logic        clk, rst, ce, ext, auto, su, sn, lk1k, its, demand, prio, ack, done, taken, rxf;
  logic        req, we, txs, go, drop, enq, uerr, nerr, uprim, nprim;
  logic [15:0] presc, uper, nper, tper, rdata, wdata;
  logic [23:0] tbase, lbase, maddr, rdesc;
  logic [12:0] rxa, rent;
  ccs_lmi_ev_t ev;
  ccs_tx_req_t treq;
  logic [47:0] exp_q [$];
  int          failures = 0;
  int          check_count = 0;

  ccs_sched #(.ADDR_W(24)) i_ccs_sched (
    .clk_i(clk), .rst_i(rst), .ce_i(ce), .timer_prescale_setting_i(presc), .extended_init_block_enable_i(ext),
    .user_poll_period_i(uper), .network_poll_period_i(nper), .transmit_poll_period_i(tper), .lmi_auto_i(auto),
    .lmi_ev_i(ev), .start_user_poll_i(su), .start_network_poll_i(sn), .context_table_base_i(tbase),
    .address_lookup_table_base_i(lbase), .lookup_1k_i(lk1k), .info_transfer_start_i(its),
    .transmit_demand_i(demand), .priority_transmit_demand_i(prio), .mem_ack_i(ack), .mem_rdata_i(rdata),
    .tx_done_i(done), .tx_taken_i(taken), .rx_frame_i(rxf), .rx_addr_i(rxa), .mem_req_o(req), .mem_we_o(we),
    .mem_addr_o(maddr), .mem_wdata_o(wdata), .tx_start_o(txs), .tx_req_o(treq), .rx_go_o(go), .rx_drop_o(drop),
    .rx_entry_o(rent), .rx_desc_o(rdesc), .send_enquiry_o(enq), .user_poll_err_o(uerr),
    .network_poll_err_o(nerr), .user_poll_prim_o(uprim), .network_poll_prim_o(nprim));
  ccs_mem_model #(.ADDR_W(24)) i_ccs_mem_model (
    .clk_i(clk), .req_i(req), .we_i(we), .addr_i(maddr), .wdata_i(wdata), .ack_o(ack), .rdata_o(rdata));

  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic note(input logic [47:0] got);
    if (exp_q.size() == 0)
    begin
      failures++;
      $display("mismatch at %0t: unexpected event %h", $time, got);
    end
    else
      check(got, exp_q.pop_front());
  endtask : note
  task automatic drain(output int n);
    n = 0;
    while (exp_q.size() != 0 && n < 20000)
    begin
      @(posedge clk);
      n++;
    end
    if (exp_q.size() != 0)
    begin
      failures++;
      $display("mismatch at %0t: expected event missing", $time);
      exp_q.delete();
    end
  endtask : drain
  task automatic timer_case(input logic x, input logic [15:0] s, input logic net, input int lo, input int hi);
    int n;
    ext <= x;
    presc <= s;
    exp_q.push_back({net ? 3'd7 : 3'd6, 45'h0});
    @(posedge clk);
    su <= !net;
    sn <= net;
    @(posedge clk);
    su <= 1'b0;
    sn <= 1'b0;
    drain(n);
    check({47'h0, n >= lo && n <= hi}, 48'h1);
    $display("timer case done after %0d cycles", n);
  endtask : timer_case
  task automatic lmi_case(input logic [4:0] e1, input logic [4:0] e2, input logic [2:0] k, input logic b);
    int n;
    if (k != 3'd0)
      exp_q.push_back({k, 44'h0, b});
    ev <= ccs_lmi_ev_t'(e1);
    @(posedge clk);
    ev <= ccs_lmi_ev_t'(e2);
    @(posedge clk);
    ev <= '0;
    if (k != 3'd0)
      drain(n);
    else
      repeat (300) @(posedge clk);
  endtask : lmi_case
  task automatic rx_case(input logic [12:0] a, input logic k, input logic [47:0] e);
    int n;
    exp_q.push_back(e);
    lk1k <= k;
    rxa <= a;
    rxf <= 1'b1;
    @(posedge clk);
    rxf <= 1'b0;
    drain(n);
  endtask : rx_case
  task automatic pulse_demand_and_drain(input logic [47:0] e);
    int n;
    exp_q.push_back(e);
    demand <= 1'b1;
    @(posedge clk);
    demand <= 1'b0;
    drain(n);
  endtask : pulse_demand_and_drain
  task automatic tx_reply(input logic t);
    repeat (4) @(posedge clk);
    done <= 1'b1;
    taken <= t;
    @(posedge clk);
    done <= 1'b0;
    taken <= 1'b0;
  endtask : tx_reply
  task automatic finish_test;
    $display("checks made %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (!rst && txs) note({3'd1, treq.entry, treq.addr_field});
    if (!rst && go) note({3'd2, rent, 8'h00, rdesc});
    if (!rst && drop) note({3'd3, 45'h0});
    if (!rst && enq) note({3'd4, 44'h0, uerr});
    if (!rst && nerr) note({3'd5, 45'h0});
    if (!rst && uprim) note({3'd6, 45'h0});
    if (!rst && nprim) note({3'd7, 45'h0});
  end
  initial
  begin
    repeat (50000) @(posedge clk);
    failures++;
    $display("mismatch at %0t: run did not finish", $time);
    finish_test();
  end
  initial
  begin
    {rst, ce} = 2'b11;
    {ext, auto, su, sn, lk1k, its, demand, prio, done, taken, rxf} = '0;
    {presc, uper, nper, tper} = {16'h0001, 16'hfffe, 16'hfffd, 16'h8000};
    {tbase, lbase, rxa, ev} = {24'h001000, 24'h008000, 13'h0000, 5'h00};
    void'($urandom(32'h8ce232c8));
    foreach (INIT_TAB[i]) i_ccs_mem_model.poke(INIT_TAB[i][39:16], INIT_TAB[i][15:0]);
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    timer_case(1'b0, 16'h0001, 1'b0, 64, 134);
    timer_case(1'b0, 16'h0001, 1'b1, 128, 200);
    timer_case(1'b0, 16'h0101, 1'b0, 64, 134);
    timer_case(1'b1, 16'h0101, 1'b0, 8224, 16452);
    auto <= 1'b1;
    ext <= 1'b0;
    presc <= 16'h0001;
    lmi_case(5'h10, 5'h00, 3'd4, 1'b1);
    lmi_case(5'h10, 5'h02, 3'd4, 1'b0);
    lmi_case(5'h08, 5'h00, 3'd5, 1'b0);
    lmi_case(5'h08, 5'h04, 3'd0, 1'b0);
    lmi_case(5'h11, 5'h00, 3'd0, 1'b0);
    $display("link timer cases done");
    rx_case(13'h0003, 1'b0, {3'd2, 13'd1, 8'h00, 24'h006008});
    rx_case(13'h0004, 1'b0, {3'd3, 45'h0});
    rx_case(13'h0005, 1'b0, {3'd3, 45'h0});
    rx_case({3'($urandom_range(7, 1)), 10'h003}, 1'b1, {3'd2, 13'd1, 8'h00, 24'h006008});
    $display("receive cases done");
    its <= 1'b1;
    @(posedge clk);
    its <= 1'b0;
    repeat (300) @(posedge clk);
    pulse_demand_and_drain({3'd1, 13'd1, 32'h12345678});
    tx_reply(1'b1);
    repeat (60) @(posedge clk);
    pulse_demand_and_drain({3'd1, 13'd5, 32'h9abcdef0});
    i_ccs_mem_model.poke(24'h0010a0, 16'h0100);
    tx_reply(1'b0);
    i_ccs_mem_model.poke(24'h001000, 16'h8000);
    i_ccs_mem_model.poke(24'h000000, 16'h8000);
    prio <= 1'b1;
    @(posedge clk);
    prio <= 1'b0;
    pulse_demand_and_drain({3'd1, 13'd0, 32'h00000000});
    tx_reply(1'b0);
    repeat (300) @(posedge clk);
    check({32'h0, i_ccs_mem_model.peek(24'h001022)}, 48'h000000000200);
    check({32'h0, i_ccs_mem_model.peek(24'h0010a2)}, 48'h000000000000);
    $display("scan cases done");
    finish_test();
  end
endmodule : ccs_sched_tb
`default_nettype wire

// ### hw/ccs_pkg.sv
// constants and carrier types of the channel context scheduler
package ccs_pkg;
  localparam logic [4:0]  CCS_STEP_LAST    = 5'h1f;
  localparam int          CCS_ENTRY_SHIFT  = 5;
  localparam int          CCS_DESC_SHIFT   = 3;
  localparam int          CCS_ALT_SHIFT    = 1;
  localparam logic [7:0]  CCS_OFS_CTL      = 8'h00;
  localparam logic [7:0]  CCS_OFS_TXRING   = 8'h02;
  localparam logic [7:0]  CCS_OFS_TXRINGLO = 8'h04;
  localparam logic [7:0]  CCS_OFS_ADDR_HI  = 8'h06;
  localparam logic [7:0]  CCS_OFS_ADDR_LO  = 8'h08;
  localparam logic [7:0]  CCS_OFS_JUMP     = 8'h10;
  localparam logic [7:0]  CCS_OFS_RX       = 8'h12;
  localparam logic [7:0]  CCS_OFS_RXRING   = 8'h14;
  localparam logic [7:0]  CCS_OFS_RXRINGLO = 8'h16;
  localparam int          CCS_TX_CHANNEL_READY_BIT    = 15;
  localparam int          CCS_JUMP_BIT     = 13;
  localparam int          CCS_END_BIT      = 8;
  localparam int          CCS_OWN_BIT      = 15;
  localparam int          CCS_RX_CHANNEL_READY_BIT    = 15;
  localparam int          CCS_ACTIVE_BIT   = 15;
  localparam logic [12:0] CCS_MGMT_ENTRY   = 13'h0000;
  localparam logic [12:0] CCS_FIRST_ENTRY  = 13'h0001;
  localparam logic [12:0] CCS_ADDR_1K_MASK = 13'h03ff;

  typedef enum logic [15:0] {
    CCS_IDLE   = 16'h0001, CCS_WAIT_TP = 16'h0002, CCS_CTL    = 16'h0004, CCS_JUMP  = 16'h0008,
    CCS_RING   = 16'h0010, CCS_RINGLO  = 16'h0020, CCS_DESC   = 16'h0040, CCS_AHI   = 16'h0080,
    CCS_ALO    = 16'h0100, CCS_TX      = 16'h0200, CCS_WB     = 16'h0400, CCS_NEXT  = 16'h0800,
    CCS_ALT    = 16'h1000, CCS_RXC     = 16'h2000, CCS_RXR    = 16'h4000, CCS_RXRLO = 16'h8000
  } ccs_state_t;

  typedef struct packed {
    logic enq_sent;
    logic status_sent;
    logic enq_rcvd;
    logic status_rcvd;
    logic second_seq;
  } ccs_lmi_ev_t;

  typedef struct packed {
    logic [12:0] entry;
    logic [31:0] addr_field;
    logic [23:0] desc_addr;
  } ccs_tx_req_t;
endpackage : ccs_pkg

// ### hw/ccs_sched.sv
// channel context scheduler: prescaled poll timers, transmit scanner, receive lookup
`timescale 1ns/1ps
`default_nettype none

module ccs_poll_timer (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        start_i,
  input  wire logic        tick_i,
  input  wire logic [15:0] period_i,
  output logic             expire_o
);
  logic [15:0] cnt_reg, cnt_next;
  logic        run_reg, run_next, exp_next;

  always_comb
  begin
    cnt_next = cnt_reg;
    run_next = run_reg;
    exp_next = 1'b0;
    if (start_i)
    begin
      cnt_next = period_i;
      run_next = 1'b1;
    end
    else if (tick_i && run_reg)
    begin
      cnt_next = cnt_reg + 16'h0001;
      if (cnt_next == 16'h0000)
      begin
        run_next = 1'b0;
        exp_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_reg  <= 16'h0000;
      run_reg  <= 1'b0;
      expire_o <= 1'b0;
    end
    else if (ce_i)
    begin
      cnt_reg  <= cnt_next;
      run_reg  <= run_next;
      expire_o <= exp_next;
    end
  end
endmodule : ccs_poll_timer

module ccs_sched import ccs_pkg::*; #(
  parameter int ADDR_W = 24
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  input  wire logic [15:0]       timer_prescale_setting_i,
  input  wire logic              extended_init_block_enable_i,
  input  wire logic [15:0]       user_poll_period_i,
  input  wire logic [15:0]       network_poll_period_i,
  input  wire logic [15:0]       transmit_poll_period_i,
  input  wire logic              lmi_auto_i,
  input  wire ccs_lmi_ev_t       lmi_ev_i,
  input  wire logic              start_user_poll_i,
  input  wire logic              start_network_poll_i,
  input  wire logic [ADDR_W-1:0] context_table_base_i,
  input  wire logic [ADDR_W-1:0] address_lookup_table_base_i,
  input  wire logic              lookup_1k_i,
  input  wire logic              info_transfer_start_i,
  input  wire logic              transmit_demand_i,
  input  wire logic              priority_transmit_demand_i,
  input  wire logic              mem_ack_i,
  input  wire logic [15:0]       mem_rdata_i,
  input  wire logic              tx_done_i,
  input  wire logic              tx_taken_i,
  input  wire logic              rx_frame_i,
  input  wire logic [12:0]       rx_addr_i,
  output logic                   mem_req_o,
  output logic                   mem_we_o,
  output logic [ADDR_W-1:0]      mem_addr_o,
  output logic [15:0]            mem_wdata_o,
  output logic                   tx_start_o,
  output ccs_tx_req_t            tx_req_o,
  output logic                   rx_go_o,
  output logic                   rx_drop_o,
  output logic [12:0]            rx_entry_o,
  output logic [ADDR_W-1:0]      rx_desc_o,
  output logic                   send_enquiry_o,
  output logic                   user_poll_err_o,
  output logic                   network_poll_err_o,
  output logic                   user_poll_prim_o,
  output logic                   network_poll_prim_o
);
  initial
  begin
    if (ADDR_W < 24 || ADDR_W > 32)
      $error("ccs_sched: ADDR_W must be 24 to 32");
  end

  // prescaler and timer tick
  logic [4:0]  step_reg, step_next;
  logic [16:0] pre_reg, pre_next, pre_load;
  logic [15:0] set_m1;
  logic        tick_reg, tick_next;

  always_comb
  begin
    set_m1    = extended_init_block_enable_i ? timer_prescale_setting_i - 16'h0001
              : {8'h00, timer_prescale_setting_i[7:0] - 8'h01};
    pre_load  = {1'b0, set_m1} + 17'h00001;
    step_next = step_reg + 5'h01;
    pre_next  = pre_reg;
    tick_next = 1'b0;
    if (step_reg == CCS_STEP_LAST)
    begin
      if (pre_reg == 17'h00000)
      begin
        pre_next  = pre_load;
        tick_next = 1'b1;
      end
      else
        pre_next = pre_reg - 17'h00001;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      step_reg <= 5'h00;
      pre_reg  <= 17'h00000;
      tick_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      step_reg <= step_next;
      pre_reg  <= pre_next;
      tick_reg <= tick_next;
    end
  end

  // link-management and transmit poll timers
  logic t1_start, t2_start, t1_exp, t2_exp, tp_exp, tp_start;
  logic stat_seen_reg, stat_seen_next, enq_seen_reg, enq_seen_next;
  logic send_next, uerr_next, nerr_next, uprim_next, nprim_next;

  ccs_poll_timer u_user_poll (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .start_i(t1_start),
    .tick_i(tick_reg), .period_i(user_poll_period_i), .expire_o(t1_exp));
  ccs_poll_timer u_network_poll (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .start_i(t2_start),
    .tick_i(tick_reg), .period_i(network_poll_period_i), .expire_o(t2_exp));
  ccs_poll_timer u_transmit_poll (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .start_i(tp_start),
    .tick_i(tick_reg), .period_i(transmit_poll_period_i), .expire_o(tp_exp));

  always_comb
  begin
    t1_start = lmi_auto_i ? (lmi_ev_i.enq_sent && !lmi_ev_i.second_seq) : start_user_poll_i;
    t2_start = lmi_auto_i ? (lmi_ev_i.status_sent && !lmi_ev_i.second_seq) : start_network_poll_i;
    stat_seen_next = t1_start ? 1'b0 : stat_seen_reg;
    enq_seen_next  = t2_start ? 1'b0 : enq_seen_reg;
    // a reply in the restart cycle is kept
    if (lmi_ev_i.status_rcvd && !lmi_ev_i.second_seq)
      stat_seen_next = 1'b1;
    if (lmi_ev_i.enq_rcvd && !lmi_ev_i.second_seq)
      enq_seen_next = 1'b1;
    send_next  = t1_exp && lmi_auto_i;
    uerr_next  = t1_exp && lmi_auto_i && !stat_seen_reg;
    nerr_next  = t2_exp && lmi_auto_i && !enq_seen_reg;
    uprim_next = t1_exp && !lmi_auto_i;
    nprim_next = t2_exp && !lmi_auto_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      stat_seen_reg       <= 1'b0;
      enq_seen_reg        <= 1'b0;
      send_enquiry_o      <= 1'b0;
      user_poll_err_o     <= 1'b0;
      network_poll_err_o  <= 1'b0;
      user_poll_prim_o    <= 1'b0;
      network_poll_prim_o <= 1'b0;
    end
    else if (ce_i)
    begin
      stat_seen_reg       <= stat_seen_next;
      enq_seen_reg        <= enq_seen_next;
      send_enquiry_o      <= send_next;
      user_poll_err_o     <= uerr_next;
      network_poll_err_o  <= nerr_next;
      user_poll_prim_o    <= uprim_next;
      network_poll_prim_o <= nprim_next;
    end
  end

  // scanner and receive lookup
  function automatic logic [ADDR_W-1:0] ct_addr(input logic [ADDR_W-1:0] base, input logic [12:0] idx,
                                                 input logic [7:0] ofs);
    ct_addr = base + (ADDR_W'(idx) << CCS_ENTRY_SHIFT) + ADDR_W'(ofs);
  endfunction : ct_addr

  ccs_state_t          st_reg, st_next, ret_reg, ret_next;
  logic [12:0]         ent_reg, ent_next, rxe_reg, rxe_next, rxa_reg, rxa_next;
  logic [15:0]         ctl_reg, ctl_next, ringw_reg, ringw_next, ahi_reg, ahi_next, rxw_reg, rxw_next;
  logic [ADDR_W-1:0]   ring_reg, ring_next, desc_reg, desc_next, addr_next, rxd_next, wait_ofs;
  logic                req_next, we_next, txs_next, rgo_next, rdrop_next, got;
  logic                svc_reg, svc_next, rxp_reg, rxp_next, ptd_reg, ptd_next;
  logic [15:0]         wdata_next;
  ccs_tx_req_t         txr_next;

  always_comb
  begin
    st_next = st_reg;  ret_next = ret_reg;  ent_next = ent_reg;  rxe_next = rxe_reg;
    rxa_next = rxa_reg;  ctl_next = ctl_reg;  ringw_next = ringw_reg;  ahi_next = ahi_reg;
    rxw_next = rxw_reg;  ring_next = ring_reg;  desc_next = desc_reg;  svc_next = svc_reg;
    addr_next = mem_addr_o;  wdata_next = mem_wdata_o;  we_next = mem_we_o;  txr_next = tx_req_o;
    rxd_next = rx_desc_o;  txs_next = 1'b0;  rgo_next = 1'b0;  rdrop_next = 1'b0;  tp_start = 1'b0;
    rxp_next = rxp_reg;  ptd_next = ptd_reg || priority_transmit_demand_i;
    wait_ofs = '0;
    got      = mem_req_o && mem_ack_i;
    req_next = mem_req_o && !mem_ack_i;
    if (rx_frame_i)
    begin
      rxp_next = 1'b1;
      rxa_next = lookup_1k_i ? (rx_addr_i & CCS_ADDR_1K_MASK) : rx_addr_i;
    end
    case (st_reg)
      CCS_IDLE, CCS_WAIT_TP, CCS_TX:
      begin
        if (st_reg == CCS_IDLE && info_transfer_start_i)
        begin
          ent_next = CCS_FIRST_ENTRY;
          st_next  = CCS_WAIT_TP;
          tp_start = 1'b1;
        end
        else if (st_reg == CCS_WAIT_TP && (tp_exp || transmit_demand_i))
          st_next = CCS_CTL;
        else if (st_reg == CCS_TX && tx_done_i)
        begin
          st_next  = tx_taken_i ? CCS_WB : CCS_NEXT;
          svc_next = tx_taken_i;
        end
        else if (rxp_reg)
        begin
          rxp_next = rx_frame_i;
          ret_next = st_reg;
          st_next  = CCS_ALT;
        end
      end
      CCS_CTL, CCS_JUMP, CCS_RING, CCS_RINGLO, CCS_AHI, CCS_ALO, CCS_RXC, CCS_RXR, CCS_RXRLO:
      begin
        case (st_reg)
          CCS_CTL:    wait_ofs = ct_addr(context_table_base_i, ent_reg, CCS_OFS_CTL);
          CCS_JUMP:   wait_ofs = ct_addr(context_table_base_i, ent_reg, CCS_OFS_JUMP);
          CCS_RING:   wait_ofs = ct_addr(context_table_base_i, ent_reg, CCS_OFS_TXRING);
          CCS_RINGLO: wait_ofs = ct_addr(context_table_base_i, ent_reg, CCS_OFS_TXRINGLO);
          CCS_AHI:    wait_ofs = ct_addr(context_table_base_i, ent_reg, CCS_OFS_ADDR_HI);
          CCS_ALO:    wait_ofs = ct_addr(context_table_base_i, ent_reg, CCS_OFS_ADDR_LO);
          CCS_RXC:    wait_ofs = ct_addr(context_table_base_i, rxe_reg, CCS_OFS_RX);
          CCS_RXR:    wait_ofs = ct_addr(context_table_base_i, rxe_reg, CCS_OFS_RXRING);
          default:    wait_ofs = ct_addr(context_table_base_i, rxe_reg, CCS_OFS_RXRINGLO);
        endcase
        if (!mem_req_o)
        begin
          req_next  = 1'b1;
          we_next   = 1'b0;
          addr_next = wait_ofs;
        end
        else if (got)
        begin
          case (st_reg)
            CCS_CTL:
            begin
              ctl_next = mem_rdata_i;
              st_next  = mem_rdata_i[CCS_TX_CHANNEL_READY_BIT] ? CCS_RING : CCS_NEXT;
            end
            CCS_JUMP:
            begin
              ent_next = mem_rdata_i[15:3];
              st_next  = svc_reg ? CCS_WAIT_TP : CCS_CTL;
              tp_start = svc_reg;
              svc_next = 1'b0;
            end
            CCS_RING:
            begin
              ringw_next = mem_rdata_i;
              st_next    = CCS_RINGLO;
            end
            CCS_RINGLO:
            begin
              ring_next = ADDR_W'({ringw_reg[7:0], mem_rdata_i});
              st_next   = CCS_DESC;
            end
            CCS_AHI:
            begin
              ahi_next = mem_rdata_i;
              st_next  = CCS_ALO;
            end
            CCS_ALO:
            begin
              txr_next = '{entry: ent_reg, addr_field: {ahi_reg, mem_rdata_i}, desc_addr: 24'(desc_reg)};
              txs_next = 1'b1;
              st_next  = CCS_TX;
            end
            CCS_RXC:
            begin
              rxw_next = mem_rdata_i;
              st_next  = mem_rdata_i[CCS_RX_CHANNEL_READY_BIT] ? CCS_RXR : ret_reg;
              rdrop_next = !mem_rdata_i[CCS_RX_CHANNEL_READY_BIT];
            end
            CCS_RXR:
            begin
              ring_next = ring_reg;
              ahi_next  = ahi_reg;
              rxd_next  = ADDR_W'({mem_rdata_i[7:0], 16'h0000});
              st_next   = CCS_RXRLO;
            end
            default:
            begin
              rxd_next = rx_desc_o + ADDR_W'(mem_rdata_i)
                       + (ADDR_W'(rxw_reg[14:8]) << CCS_DESC_SHIFT);
              rgo_next = 1'b1;
              st_next  = ret_reg;
            end
          endcase
        end
      end
      CCS_DESC:
      begin
        if (!mem_req_o)
        begin
          req_next  = 1'b1;
          we_next   = 1'b0;
          desc_next = ring_reg + (ADDR_W'(ringw_reg[15:9]) << CCS_DESC_SHIFT);
          addr_next = desc_next;
        end
        else if (got)
          st_next = mem_rdata_i[CCS_OWN_BIT] ? CCS_AHI : CCS_NEXT;
      end
      CCS_WB:
      begin
        if (!mem_req_o)
        begin
          req_next   = 1'b1;
          we_next    = 1'b1;
          addr_next  = ct_addr(context_table_base_i, ent_reg, CCS_OFS_TXRING);
          wdata_next = {ringw_reg[15:9] + 7'h01, ringw_reg[8:0]};
        end
        else if (got)
        begin
          we_next = 1'b0;
          st_next = CCS_NEXT;
        end
      end
      CCS_NEXT:
      begin
        st_next = svc_reg ? CCS_WAIT_TP : CCS_CTL;
        if (ptd_reg)
        begin
          ptd_next = priority_transmit_demand_i;
          ent_next = CCS_MGMT_ENTRY;
        end
        else if (ctl_reg[CCS_JUMP_BIT])
          st_next = CCS_JUMP;
        else
          ent_next = ctl_reg[CCS_END_BIT] ? CCS_FIRST_ENTRY : ent_reg + 13'h0001;
        if (st_next == CCS_WAIT_TP)
        begin
          tp_start = 1'b1;
          svc_next = 1'b0;
        end
      end
      CCS_ALT:
      begin
        if (!mem_req_o)
        begin
          req_next  = 1'b1;
          we_next   = 1'b0;
          addr_next = address_lookup_table_base_i + (ADDR_W'(rxa_reg) << CCS_ALT_SHIFT);
        end
        else if (got)
        begin
          rxe_next   = mem_rdata_i[12:0];
          st_next    = mem_rdata_i[CCS_ACTIVE_BIT] ? CCS_RXC : ret_reg;
          rdrop_next = !mem_rdata_i[CCS_ACTIVE_BIT];
        end
      end
      default:
        st_next = CCS_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_reg <= CCS_IDLE;  ret_reg <= CCS_IDLE;  ent_reg <= CCS_FIRST_ENTRY;  rxe_reg <= '0;
      rxa_reg <= '0;  ctl_reg <= '0;  ringw_reg <= '0;  ahi_reg <= '0;  rxw_reg <= '0;
      ring_reg <= '0;  desc_reg <= '0;  svc_reg <= 1'b0;  rxp_reg <= 1'b0;  ptd_reg <= 1'b0;
      mem_req_o <= 1'b0;  mem_we_o <= 1'b0;  mem_addr_o <= '0;  mem_wdata_o <= '0;
      tx_start_o <= 1'b0;  tx_req_o <= '0;  rx_go_o <= 1'b0;  rx_drop_o <= 1'b0;
      rx_entry_o <= '0;  rx_desc_o <= '0;
    end
    else if (ce_i)
    begin
      st_reg <= st_next;  ret_reg <= ret_next;  ent_reg <= ent_next;  rxe_reg <= rxe_next;
      rxa_reg <= rxa_next;  ctl_reg <= ctl_next;  ringw_reg <= ringw_next;  ahi_reg <= ahi_next;
      rxw_reg <= rxw_next;  ring_reg <= ring_next;  desc_reg <= desc_next;  svc_reg <= svc_next;
      rxp_reg <= rxp_next;  ptd_reg <= ptd_next;
      mem_req_o <= req_next;  mem_we_o <= we_next;  mem_addr_o <= addr_next;  mem_wdata_o <= wdata_next;
      tx_start_o <= txs_next;  tx_req_o <= txr_next;  rx_go_o <= rgo_next;  rx_drop_o <= rdrop_next;
      rx_entry_o <= rxe_next;  rx_desc_o <= rxd_next;
    end
  end
endmodule : ccs_sched

`default_nettype wire
